/* common/strap_pkg.sv */
// constants for the strap option capture block
// assumes a 100 MHz core clock and board pull resistors on the strap pins
package strap_pkg;
  localparam logic [10:0] frame_max_untagged = 11'd1518;
  localparam logic [10:0] frame_max_tagged = 11'd1522;
  localparam logic [10:0] frame_max_large = 11'd1536;
  localparam int strap_count = 8;
  localparam int pos_xover = 0;
  localparam int pos_fc = 1;
  localparam int pos_bp = 2;
  localparam int pos_coll = 3;
  localparam int pos_backoff = 4;
  localparam int pos_frame = 5;
  localparam int pos_p4_duplex = 6;
  localparam int pos_p4_fc = 7;
  localparam logic [7:0] strap_reset_value = 8'h00;
  localparam logic port5_phy_mode_default = 1'b1;
endpackage : strap_pkg

/* hdl/sync2.sv */
// two-flop synchroniser for a bus of asynchronous pin levels
// assumes inputs are quasi-static or may be sampled with one cycle of doubt
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
  parameter int width = 1,
  parameter logic [width-1:0] reset_value = '0
) (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic [width-1:0] async_in,
  output logic [width-1:0] sync_out
);
  logic [width-1:0] meta;
  logic [width-1:0] next_meta;
  logic [width-1:0] next_sync;

  // refused while elaborating, so a bad width never builds
  if (width < 1)
  begin : g_bad_width
    $error("sync2 width must be at least 1");
  end

  always_comb
  begin
    next_meta = async_in;
    next_sync = meta;
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      // both stages clear to reset_value, the pin's idle level, which defaults to zero
      meta <= reset_value;
      sync_out <= reset_value;
    end
    else
    begin
      meta <= next_meta;
      sync_out <= next_sync;
    end
  end
endmodule : sync2
`default_nettype wire

/* hdl/strap_option_capture.sv */
// strap option capture: latches board straps at reset release into config bits
// assumes straps are stable across reset release; one 100 MHz clock domain
`timescale 1ns/10ps
`default_nettype none
module strap_option_capture
  import strap_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic crossover_disable_strap_in,
  input wire logic flow_ctrl_strap_in,
  input wire logic back_pressure_strap_in,
  input wire logic collision_drop_strap_in,
  input wire logic backoff_strap_in,
  input wire logic frame_size_strap_in,
  input wire logic port4_duplex_strap_in,
  input wire logic port4_force_fc_strap_in,
  input wire logic chip_power_down_n_in,
  input wire logic irq_request_in,
  output logic strap_pins_oe_out,
  output logic strap_pulldown_en_out,
  output logic auto_crossover_en_out,
  output logic flow_ctrl_en_out,
  output logic back_pressure_en_out,
  output logic collision_drop_en_out,
  output logic aggressive_backoff_en_out,
  output logic [10:0] frame_max_tagged_out,
  output logic [10:0] frame_max_untagged_out,
  output logic port4_force_full_duplex_out,
  output logic port4_force_fc_out,
  output logic port5_switch_mii_phy_mode_out,
  output logic chip_power_down_out,
  output logic irq_open_drain_n_out,
  output logic irq_open_drain_n_oe_out,
  output logic straps_valid_out
);
  typedef enum logic [1:0] {in_reset, settle, sample, running} cap_state_e;

  logic [strap_count-1:0] pins_raw;
  logic [strap_count-1:0] pins_sync;
  logic pwr_sync;
  cap_state_e state;
  cap_state_e next_state;
  logic [strap_count-1:0] straps;
  logic [strap_count-1:0] next_straps;
  logic next_oe;
  logic next_pulldown;
  logic next_valid;
  logic next_xover;
  logic next_fc;
  logic next_bp;
  logic next_coll;
  logic next_backoff;
  logic [10:0] next_max_tag;
  logic [10:0] next_max_untag;
  logic next_p4_duplex;
  logic next_p4_fc;
  logic next_pd;
  logic next_irq_oe;

  assign pins_raw[pos_xover] = crossover_disable_strap_in;
  assign pins_raw[pos_fc] = flow_ctrl_strap_in;
  assign pins_raw[pos_bp] = back_pressure_strap_in;
  assign pins_raw[pos_coll] = collision_drop_strap_in;
  assign pins_raw[pos_backoff] = backoff_strap_in;
  assign pins_raw[pos_frame] = frame_size_strap_in;
  assign pins_raw[pos_p4_duplex] = port4_duplex_strap_in;
  assign pins_raw[pos_p4_fc] = port4_force_fc_strap_in;

  // one capture bit per strap pin; the port list is fixed at eight
  if (strap_count != 8)
  begin : g_bad_strap_count
    $error("strap_count must match the eight strap pins");
  end

  // pos_frame and pos_p4_fc must land inside the capture vector
  if (pos_p4_fc >= strap_count || pos_frame >= strap_count)
  begin : g_bad_strap_pos
    $error("strap position outside the capture vector");
  end

  // board pins are asynchronous to the core clock
  // strap stages clear to the pull-down level seen during reset
  sync2 #(
    .width(strap_count),
    .reset_value(strap_reset_value)
  ) pin_sync (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .async_in(pins_raw),
    .sync_out(pins_sync)
  );

  // power-down stages clear to the idle high level, so reset
  // release never shows a false power-down request
  sync2 #(
    .width(1),
    .reset_value(1'b1)
  ) pwr_sync_stage (
    .ref_clk_in(ref_clk_in),
    .reset_in(reset_in),
    .async_in(chip_power_down_n_in),
    .sync_out(pwr_sync)
  );

  always_comb
  begin
    next_state = state;
    next_straps = straps;
    case (state)
      in_reset:
      begin
        // first stage takes the pin level on this edge
        next_state = settle;
      end
      settle:
      begin
        // second stage takes the post-reset pin level on this edge
        next_state = sample;
      end
      sample:
      begin
        next_straps = pins_sync;
        next_state = running;
      end
      running:
      begin
        next_state = running;
      end
      default:
      begin
        next_state = in_reset;
      end
    endcase
    // pull-downs in reset, drive after capture
    next_pulldown = (next_state != running);
    next_oe = (next_state == running);
    next_valid = (next_state == running);
    next_xover = ~next_straps[pos_xover];
    next_fc = ~next_straps[pos_fc];
    next_bp = next_straps[pos_bp];
    next_coll = ~next_straps[pos_coll];
    next_backoff = next_straps[pos_backoff];
    next_max_tag = next_straps[pos_frame] ? frame_max_large : frame_max_tagged;
    next_max_untag = next_straps[pos_frame] ? frame_max_large : frame_max_untagged;
    next_p4_duplex = next_straps[pos_p4_duplex];
    next_p4_fc = next_straps[pos_p4_fc];
  end

  // pin pass-through group, live in every capture state
  always_comb
  begin
    next_pd = ~pwr_sync;
    // drive low only to assert, else release
    next_irq_oe = irq_request_in;
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      state <= in_reset;
      straps <= strap_reset_value;
      strap_pins_oe_out <= 1'b0;
      strap_pulldown_en_out <= 1'b1;
      straps_valid_out <= 1'b0;
      auto_crossover_en_out <= 1'b1;
      flow_ctrl_en_out <= 1'b1;
      back_pressure_en_out <= 1'b0;
      collision_drop_en_out <= 1'b1;
      aggressive_backoff_en_out <= 1'b0;
      frame_max_tagged_out <= frame_max_tagged;
      frame_max_untagged_out <= frame_max_untagged;
      port4_force_full_duplex_out <= 1'b0;
      port4_force_fc_out <= 1'b0;
      port5_switch_mii_phy_mode_out <= port5_phy_mode_default;
    end
    else
    begin
      state <= next_state;
      straps <= next_straps;
      strap_pins_oe_out <= next_oe;
      strap_pulldown_en_out <= next_pulldown;
      straps_valid_out <= next_valid;
      auto_crossover_en_out <= next_xover;
      flow_ctrl_en_out <= next_fc;
      back_pressure_en_out <= next_bp;
      collision_drop_en_out <= next_coll;
      aggressive_backoff_en_out <= next_backoff;
      frame_max_tagged_out <= next_max_tag;
      frame_max_untagged_out <= next_max_untag;
      port4_force_full_duplex_out <= next_p4_duplex;
      port4_force_fc_out <= next_p4_fc;
      port5_switch_mii_phy_mode_out <= port5_phy_mode_default;
    end
  end

  always_ff @(posedge ref_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      // held off in reset: the core is being reset anyway
      chip_power_down_out <= 1'b0;
      // pin data stays low; only the enable moves
      irq_open_drain_n_out <= 1'b0;
      irq_open_drain_n_oe_out <= 1'b0;
    end
    else
    begin
      chip_power_down_out <= next_pd;
      irq_open_drain_n_out <= 1'b0;
      irq_open_drain_n_oe_out <= next_irq_oe;
    end
  end
endmodule : strap_option_capture
`default_nettype wire

/* test/board_straps.sv */
// board resistors: one pull per strap pin, pull-up on power-down line
// assumes the bench picks which straps are pulled up
`timescale 1ns/10ps
`default_nettype none
module board_straps (
  input wire logic [7:0] pull_up_in,
  input wire logic power_down_req_in,
  output logic [7:0] strap_out,
  output logic chip_power_down_n_out
);
  assign strap_out = pull_up_in;
  assign chip_power_down_n_out = !power_down_req_in;
endmodule : board_straps
`default_nettype wire

/* test/strap_option_capture_checker.sv */
// checker on strap capture ports
// assumes one core clock, async active-high reset
`timescale 1ns/10ps
`default_nettype none
module strap_option_capture_checker
  import strap_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic crossover_disable_strap_in,
  input wire logic flow_ctrl_strap_in,
  input wire logic frame_size_strap_in,
  input wire logic chip_power_down_n_in,
  input wire logic irq_request_in,
  input wire logic strap_pins_oe_out,
  input wire logic strap_pulldown_en_out,
  input wire logic auto_crossover_en_out,
  input wire logic flow_ctrl_en_out,
  input wire logic [10:0] frame_max_untagged_out,
  input wire logic chip_power_down_out,
  input wire logic irq_open_drain_n_out,
  input wire logic irq_open_drain_n_oe_out,
  input wire logic straps_valid_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  xover_map_a:
    assert property ($rose(straps_valid_out) |-> auto_crossover_en_out != crossover_disable_strap_in)
    else $error("crossover map wrong");
  flow_map_a:
    assert property ($rose(straps_valid_out) |-> flow_ctrl_en_out != flow_ctrl_strap_in)
    else $error("flow control map wrong");
  frame_size_a:
    assert property ($rose(straps_valid_out) |-> frame_max_untagged_out ==
      (frame_size_strap_in ? frame_max_large : frame_max_untagged))
    else $error("frame size wrong");
  power_down_a:
    assert property (!chip_power_down_n_in [*4] |-> chip_power_down_out)
    else $error("power-down missed");
  irq_drive_a:
    assert property (1 |=> irq_open_drain_n_oe_out == $past(irq_request_in)
      && !irq_open_drain_n_out)
    else $error("irq pin wrong");
  config_hold_a:
    assert property ($past(straps_valid_out) |-> $stable({auto_crossover_en_out,
      flow_ctrl_en_out, frame_max_untagged_out}))
    else $error("config changed");
  pin_mode_a:
    assert property (strap_pins_oe_out == straps_valid_out
      && strap_pulldown_en_out != straps_valid_out)
    else $error("pin mode wrong");
  capture_time_a:
    assert property ($fell(reset_in) |-> !straps_valid_out ##[1:3] straps_valid_out)
    else $error("capture late");
  pd_release_a:
    assert property ($fell(reset_in) |-> !chip_power_down_out [*3])
    else $error("false power-down after reset");
  cover property ($rose(straps_valid_out));
  cover property ($rose(irq_open_drain_n_oe_out));
  cover property ($rose(chip_power_down_out));
endmodule : strap_option_capture_checker
bind strap_option_capture strap_option_capture_checker i_strap_option_capture_checker (.*);
`default_nettype wire

/* test/tb.sv */
// bench: strap patterns through reset, then power-down and irq pin
// assumes board_straps as far side and the bound checker
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic ref_clk_in = 0;
  logic reset_in = 1;
  logic [7:0] pu = 0;
  logic pd_req = 0;
  logic irq_request_in = 0;
  int bad_count = 0;
  int total_checks = 0;
  wire [7:0] s;
  wire pwr_n, ax, fc, bp, cd, bo, fd, ffc, p5, cpd, irq_d, irq_oe, oe, pden, vld;
  wire [10:0] ft, fu;
  // open drain: pull-up when released
  wire irq_line = irq_oe ? irq_d : 1'b1;
  board_straps i_board_straps (.pull_up_in(pu), .power_down_req_in(pd_req),
    .strap_out(s), .chip_power_down_n_out(pwr_n));
  strap_option_capture i_strap_option_capture (.ref_clk_in, .reset_in,
    .crossover_disable_strap_in(s[0]), .flow_ctrl_strap_in(s[1]),
    .back_pressure_strap_in(s[2]), .collision_drop_strap_in(s[3]),
    .backoff_strap_in(s[4]), .frame_size_strap_in(s[5]),
    .port4_duplex_strap_in(s[6]), .port4_force_fc_strap_in(s[7]),
    .chip_power_down_n_in(pwr_n), .irq_request_in, .strap_pins_oe_out(oe),
    .strap_pulldown_en_out(pden), .auto_crossover_en_out(ax), .flow_ctrl_en_out(fc),
    .back_pressure_en_out(bp), .collision_drop_en_out(cd), .aggressive_backoff_en_out(bo),
    .frame_max_tagged_out(ft), .frame_max_untagged_out(fu),
    .port4_force_full_duplex_out(fd), .port4_force_fc_out(ffc),
    .port5_switch_mii_phy_mode_out(p5), .chip_power_down_out(cpd),
    .irq_open_drain_n_out(irq_d), .irq_open_drain_n_oe_out(irq_oe), .straps_valid_out(vld));
  initial forever #5 ref_clk_in = ~ref_clk_in;
  task chk(input string n, input logic [10:0] seen, input logic [10:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error %s expected %0d seen %0d", n, exp, seen);
    end
  endtask : chk
  task results;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : results
  initial
  begin
    int p, n;
    int q[$];
    p = $urandom(32'h056d);
    q = '{0, 255};
    repeat (4) q.push_back($urandom_range(255));
    foreach (q[i])
    begin
      p = q[i];
      @(negedge ref_clk_in);
      reset_in = 1;
      pu = p[7:0];
      repeat (20) @(negedge ref_clk_in);
      chk("pins", {pden, oe}, 2);
      reset_in = 0;
      for (n = 0; n < 10 && vld !== 1'b1; n++)
        @(negedge ref_clk_in);
      chk("valid", n < 10, 1);
      if (n == 10)
        results();
      chk("xover", ax, !p[0]);
      chk("fc", fc, !p[1]);
      chk("bp", bp, p[2]);
      chk("coll", cd, !p[3]);
      chk("backoff", bo, p[4]);
      chk("tagged", ft, p[5] ? 1536 : 1522);
      chk("untagged", fu, p[5] ? 1536 : 1518);
      chk("duplex", fd, p[6]);
      chk("forcefc", ffc, p[7]);
      chk("port5", p5, 1);
      chk("pins", {pden, oe}, 1);
      repeat (5) @(negedge ref_clk_in);
      pu = ~p[7:0];
      repeat (5) @(negedge ref_clk_in);
      chk("held", {ffc, fd, bo, cd, bp, fc, ax}, {p[7], p[6], p[4], !p[3], p[2], !p[1], !p[0]});
      $display("pattern %0h done", p);
    end
    pd_req = 1;
    repeat (4) @(negedge ref_clk_in);
    chk("pdown", cpd, 1);
    pd_req = 0;
    repeat (4) @(negedge ref_clk_in);
    chk("pdown", cpd, 0);
    $display("power-down done");
    irq_request_in = 1;
    @(negedge ref_clk_in);
    chk("irq", irq_line, 0);
    irq_request_in = 0;
    @(negedge ref_clk_in);
    chk("irq", irq_line, 1);
    $display("irq done");
    results();
  end
endmodule : tb
`default_nettype wire
